// ### design/sms_core.sv
// serial port unit: master/slave byte engine with slave-select modes
`default_nettype none
module sms_core (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_B_I,
  // ==================================================================
  // software side
  input  wire logic        MASTER_ENABLE_SET_I,
  input  wire logic        MASTER_ENABLE_CLR_I,
  input  wire logic        PORT_ENABLE_SET_I,
  input  wire logic        PORT_ENABLE_CLR_I,
  input  wire logic        CFG_WR_I,
  input  wire logic        CLOCK_PHASE_I,
  input  wire logic        CLOCK_POLARITY_I,
  input  wire logic [1:0]  SELECT_MODE_I,
  input  wire logic        DATA_WR_I,
  input  wire logic [7:0]  DATA_WR_BYTE_I,
  input  wire logic        DATA_RD_I,
  input  wire logic        DONE_CLR_I,
  input  wire logic        FAULT_CLR_I,
  output logic [7:0]       DATA_RD_BYTE_O,
  output sms_pkg::sms_cfg_t  CFG_O,
  output sms_pkg::sms_stat_t STAT_O,
  output logic             TX_READY_O,
  output logic             IRQ_REQ_O,
  // ==================================================================
  // serial pins
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE_O,
  input  wire logic        MOSI_I,
  output logic             MOSI_O,
  output logic             MOSI_OE_O,
  input  wire logic        MISO_I,
  output logic             MISO_O,
  output logic             MISO_OE_O,
  input  wire logic        SEL_I,
  output logic             SEL_O,
  output logic             SEL_OE_O,
  output logic             SEL_ROUTED_O
);
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_TRAIL} sms_phase_t;

  typedef struct packed {
    sms_pkg::sms_cfg_t  cfg;
    logic               done_flag;
    logic               fault_flag;
    logic               tx_full;
    logic [7:0]         tx_buf;
    logic [7:0]         rx_buf;
    logic               rx_full;
    logic               busy;
    sms_phase_t         phase;
    logic [7:0]         div;
    logic               sck;
    logic [7:0]         rd_byte;
    logic [2:0]         trail_cnt;
    logic               tail;
  } sms_core_state_t;

  sms_core_state_t st_reg;
  sms_core_state_t st_next;

  // ==================================================================
  // input synchronisers
  logic sel_q;
  logic sel_fall;
  logic sck_q;
  logic sck_rise;
  logic sck_fall;
  logic mosi_q;
  logic miso_q;

  sms_sync u_sel_sync (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .d_i         (SEL_I),
    .reset_val_i (1'b0),
    .q_o         (sel_q),
    .rise_o      (),
    .fall_o      (sel_fall)
  );

  sms_sync u_sck_sync (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .d_i         (SCK_I),
    .reset_val_i (1'b0),
    .q_o         (sck_q),
    .rise_o      (sck_rise),
    .fall_o      (sck_fall)
  );

  sms_sync u_mosi_sync (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .d_i         (MOSI_I),
    .reset_val_i (1'b0),
    .q_o         (mosi_q),
    .rise_o      (),
    .fall_o      ()
  );

  sms_sync u_miso_sync (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .d_i         (MISO_I),
    .reset_val_i (1'b0),
    .q_o         (miso_q),
    .rise_o      (),
    .fall_o      ()
  );

  // ==================================================================
  // mode decode
  logic is_master;
  logic enabled;
  logic mode_3wire;
  logic mode_multi;
  logic mode_sel_out;
  logic slave_selected;
  logic fault_evt;

  assign is_master      = st_reg.cfg.master_enable_bit;
  assign enabled        = st_reg.cfg.port_enable_bit;
  assign mode_3wire     = st_reg.cfg.select_mode_field == sms_pkg::SEL_MODE_3WIRE;
  assign mode_multi     = st_reg.cfg.select_mode_field == sms_pkg::SEL_MODE_MULTI;
  assign mode_sel_out   = st_reg.cfg.select_mode_field[1];
  // 3-wire slave counts itself selected at all times
  assign slave_selected = mode_3wire | (mode_multi & ~sel_q);
  assign fault_evt      = enabled & is_master & mode_multi & sel_fall;

  // ==================================================================
  // edge selection
  // leading edge is the idle-to-active edge; phase picks which edge samples
  logic lead_edge;
  logic trail_edge;
  logic m_lead;
  logic m_trail;
  logic s_lead;
  logic s_trail;
  logic sh_sample;
  logic sh_shift;
  logic sh_load;
  logic sh_clear;
  logic sh_done;
  logic sh_msb;
  logic [7:0] sh_byte;
  logic slave_active;
  logic last_trail;

  assign slave_active = enabled & ~is_master & slave_selected;
  assign s_lead  = slave_active & (st_reg.cfg.clock_polarity_bit ? sck_fall : sck_rise);
  assign s_trail = slave_active & (st_reg.cfg.clock_polarity_bit ? sck_rise : sck_fall);
  assign m_lead  = st_reg.phase == ST_LEAD && st_reg.div == 8'h00;
  assign m_trail = st_reg.phase == ST_TRAIL && st_reg.div == 8'h00;
  assign lead_edge  = is_master ? m_lead : s_lead;
  assign trail_edge = is_master ? m_trail : s_trail;
  // phase 0 samples on leading, shifts on trailing; phase 1 the reverse
  assign sh_sample = st_reg.cfg.clock_phase_bit ? trail_edge : lead_edge;
  // phase 1: the first leading edge only presents bit 7, and the last shift waits one
  // cycle past the final trailing edge so master-out holds while the far end samples it
  assign last_trail = trail_edge & (st_reg.trail_cnt == sms_pkg::BIT_COUNT_LAST);
  assign sh_shift   = st_reg.cfg.clock_phase_bit ? (lead_edge & (st_reg.trail_cnt != 3'h0)) | st_reg.tail
                                                 : trail_edge;
  assign sh_load   = st_reg.tx_full & ~st_reg.busy & enabled;
  assign sh_clear  = ~enabled | (mode_multi & ~is_master & sel_fall);

  sms_shifter u_shifter (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .clear_i     (sh_clear),
    .load_i      (sh_load),
    .load_data_i (st_reg.tx_buf),
    .sample_i    (sh_sample),
    .shift_i     (sh_shift),
    .serial_i    (is_master ? miso_q : mosi_q),
    .msb_o       (sh_msb),
    .byte_o      (sh_byte),
    .byte_done_o (sh_done)
  );

  // ==================================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.tail = st_reg.cfg.clock_phase_bit & last_trail;
    if (sh_load || sh_clear) begin
      st_next.trail_cnt = 3'h0;
    end else if (trail_edge) begin
      st_next.trail_cnt = st_reg.trail_cnt + 3'h1;
    end
    if (CFG_WR_I) begin
      st_next.cfg.clock_phase_bit    = CLOCK_PHASE_I;
      st_next.cfg.clock_polarity_bit = CLOCK_POLARITY_I;
      st_next.cfg.select_mode_field  = SELECT_MODE_I;
    end
    if (MASTER_ENABLE_SET_I) begin
      st_next.cfg.master_enable_bit = 1'b1;
    end else if (MASTER_ENABLE_CLR_I) begin
      st_next.cfg.master_enable_bit = 1'b0;
    end
    if (PORT_ENABLE_SET_I) begin
      st_next.cfg.port_enable_bit = 1'b1;
    end else if (PORT_ENABLE_CLR_I) begin
      st_next.cfg.port_enable_bit = 1'b0;
    end
    if (DATA_WR_I && !st_reg.tx_full) begin
      st_next.tx_buf  = DATA_WR_BYTE_I;
      st_next.tx_full = 1'b1;
    end
    if (DATA_RD_I) begin
      st_next.rx_full = 1'b0;
    end
    if (DONE_CLR_I) begin
      st_next.done_flag = 1'b0;
    end
    if (FAULT_CLR_I) begin
      st_next.fault_flag = 1'b0;
    end
    if (sh_load) begin
      st_next.tx_full = 1'b0;
      st_next.busy    = 1'b1;
      if (is_master) begin
        st_next.phase = ST_LEAD;
        st_next.div   = sms_pkg::SCK_HALF_CYC - 8'h01;
      end
    end
    if (st_reg.phase != ST_IDLE) begin
      if (st_reg.div != 8'h00) begin
        st_next.div = st_reg.div - 8'h01;
      end else begin
        st_next.div = sms_pkg::SCK_HALF_CYC - 8'h01;
        st_next.sck = ~st_reg.sck;
        if (st_reg.phase == ST_LEAD) begin
          st_next.phase = ST_TRAIL;
        end else begin
          st_next.phase = ST_LEAD;
        end
      end
    end
    if (sh_done) begin
      st_next.done_flag = 1'b1;
      st_next.busy      = 1'b0;
      st_next.phase     = ST_IDLE;
      st_next.sck       = 1'b0;
      if (!st_reg.rx_full || DATA_RD_I || is_master) begin
        st_next.rx_buf  = sh_byte;
        st_next.rx_full = 1'b1;
      end
    end
    if (DATA_RD_I) begin
      st_next.rd_byte = st_reg.rx_buf;
    end
    if (fault_evt) begin
      st_next.cfg.master_enable_bit = 1'b0;
      st_next.cfg.port_enable_bit   = 1'b0;
      st_next.fault_flag            = 1'b1;
      st_next.busy                  = 1'b0;
      st_next.phase                 = ST_IDLE;
      st_next.sck                   = 1'b0;
    end
    if (!st_reg.cfg.port_enable_bit) begin
      st_next.busy  = 1'b0;
      st_next.phase = ST_IDLE;
      st_next.sck   = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_reg                       <= '0;
      st_reg.cfg.select_mode_field <= sms_pkg::SEL_MODE_RESET;
      st_reg.tx_buf                <= sms_pkg::BYTE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==================================================================
  // outputs
  assign CFG_O              = st_reg.cfg;
  assign STAT_O.transfer_done_flag = st_reg.done_flag;
  assign STAT_O.mode_fault_flag    = st_reg.fault_flag;
  assign STAT_O.busy               = st_reg.busy;
  assign STAT_O.rx_full            = st_reg.rx_full;
  assign DATA_RD_BYTE_O     = st_reg.rd_byte;
  assign TX_READY_O         = ~st_reg.tx_full;
  assign IRQ_REQ_O          = st_reg.done_flag | st_reg.fault_flag;

  assign SCK_O      = st_reg.sck ^ st_reg.cfg.clock_polarity_bit;
  assign SCK_OE_O   = enabled & is_master;
  assign MOSI_O     = sh_msb;
  assign MOSI_OE_O  = enabled & is_master;
  assign MISO_O     = sh_msb;
  assign MISO_OE_O  = enabled & ~is_master & slave_selected;
  assign SEL_O      = st_reg.cfg.select_mode_field[0];
  assign SEL_OE_O   = enabled & mode_sel_out;
  assign SEL_ROUTED_O = ~mode_3wire;
endmodule : sms_core
`default_nettype wire

// ### design/sms_shifter.sv
// byte shifter: MSB-first shift with three-bit count of eight shifts
`default_nettype none
module sms_shifter (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       clear_i,
  input  wire logic       load_i,
  input  wire logic [7:0] load_data_i,
  input  wire logic       sample_i,
  input  wire logic       shift_i,
  input  wire logic       serial_i,
  output logic            msb_o,
  output logic [7:0]      byte_o,
  output logic            byte_done_o
);
  typedef struct packed {
    logic [7:0] sr;
    logic [2:0] cnt;
    logic       bit_in;
    logic       done;
  } sms_shift_state_t;

  sms_shift_state_t st_reg;
  sms_shift_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (clear_i) begin
      st_next.cnt = 3'h0;
    end
    if (load_i) begin
      st_next.sr  = load_data_i;
      st_next.cnt = 3'h0;
    end else begin
      if (sample_i) begin
        st_next.bit_in = serial_i;
      end
      if (shift_i) begin
        st_next.sr  = {st_reg.sr[6:0], sample_i ? serial_i : st_reg.bit_in};
        st_next.cnt = st_reg.cnt + 3'h1;
        if (st_reg.cnt == sms_pkg::BIT_COUNT_LAST) begin
          st_next.done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign msb_o       = st_reg.sr[7];
  assign byte_o      = st_reg.sr;
  assign byte_done_o = st_reg.done;
endmodule : sms_shifter
`default_nettype wire

// ### design/sms_sync.sv
// two-flop synchroniser with edge detection on the settled level
`default_nettype none
module sms_sync (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic d_i,
  input  wire logic reset_val_i,
  output logic      q_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } sms_sync_state_t;

  sms_sync_state_t st_reg;
  sms_sync_state_t st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  // reset value is a constant per instance: tie reset_val_i to a literal
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o    = st_reg.s2 ^ reset_val_i;
  assign rise_o = st_reg.s2 & ~st_reg.s3;
  assign fall_o = ~st_reg.s2 & st_reg.s3;
endmodule : sms_sync
`default_nettype wire

// ### pkg/sms_pkg.sv
// package of constants and carrier types for the serial port unit
// ====================================================================
// Functional notes
// - master drives master-out from shift MSB
// - master-out output as master, master-in input
// - master-in released when disabled or unselected
// - 3-wire slave always drives master-in MSB; code drives it only while the port is enabled
// - serial clock generated only as master
// - 4-wire slave ignores clock while deselected
// - mode 00: 3-wire, slave always selected
// - mode 01: 4-wire, select is an input
// - master in 01 quits on select fall
// - fault clears master and port enables
// - fault flag requests interrupt; stays disabled
// - mode 1x: select output copies low bit
// - select pin unrouted in 3-wire modes
// - reset select mode is 01
// - master data writes go to transmit buffer
// - empty shifter loads buffer, starts shifting
// - done flag set per byte, interrupt request
// - received byte MSB first into receive buffer
// - sixteen clock edges complete a byte
// - phase and polarity select edges and idle
`default_nettype none
package sms_pkg;
  // ==================================================================
  // constants
  localparam logic [1:0] SEL_MODE_3WIRE   = 2'h0;
  localparam logic [1:0] SEL_MODE_MULTI   = 2'h1;
  localparam logic [1:0] SEL_MODE_RESET   = 2'h1;
  localparam logic [2:0] BIT_COUNT_LAST   = 3'h7;
  localparam int         SCK_HALF_NS      = 80;
  localparam int         CLK_PERIOD_NS    = 20;
  localparam int         SCK_HALF_CYC_I   = (SCK_HALF_NS / CLK_PERIOD_NS) < 1 ? 1 : (SCK_HALF_NS / CLK_PERIOD_NS);
  localparam logic [7:0] SCK_HALF_CYC     = 8'(SCK_HALF_CYC_I);
  localparam logic [7:0] BYTE_RESET       = 8'h00;

  // ==================================================================
  // carriers
  typedef struct packed {
    logic       master_enable_bit;
    logic       port_enable_bit;
    logic       clock_phase_bit;
    logic       clock_polarity_bit;
    logic [1:0] select_mode_field;
  } sms_cfg_t;

  typedef struct packed {
    logic transfer_done_flag;
    logic mode_fault_flag;
    logic busy;
    logic rx_full;
  } sms_stat_t;
endpackage : sms_pkg
`default_nettype wire

// ### testbench/sms_core_chk.sv
// concurrent checks on the serial port unit top ports
`default_nettype none
module sms_core_chk (
  input wire logic               CORE_CLK_I,
  input wire logic               RST_B_I,
  input wire logic               DATA_WR_I,
  input wire logic [7:0]         DATA_WR_BYTE_I,
  input wire logic               TX_READY_O,
  input wire sms_pkg::sms_cfg_t  CFG_O,
  input wire sms_pkg::sms_stat_t STAT_O,
  input wire logic               IRQ_REQ_O,
  input wire logic               SCK_O,
  input wire logic               SCK_OE_O,
  input wire logic               MOSI_O,
  input wire logic               MOSI_OE_O,
  input wire logic               MISO_OE_O,
  input wire logic               SEL_I,
  input wire logic               SEL_O,
  input wire logic               SEL_OE_O,
  input wire logic               SEL_ROUTED_O
);
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // helper: serial clock edges since the byte started
  logic [4:0] edges_reg;
  logic       sck_reg;
  logic       busy_reg;
  logic       start_w;
  logic       master_w;
  assign master_w = CFG_O.master_enable_bit;
  assign start_w  = DATA_WR_I && TX_READY_O && master_w && CFG_O.port_enable_bit && !STAT_O.busy;
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      edges_reg <= 5'h00;
      sck_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      sck_reg  <= SCK_O;
      busy_reg <= STAT_O.busy;
      if (STAT_O.busy && !busy_reg) begin
        edges_reg <= {4'h0, SCK_O != sck_reg};
      end else if (SCK_O != sck_reg) begin
        edges_reg <= edges_reg + 5'h01;
      end
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RST_B_I);
  // ======
  // properties
  property p_mosi_msb;
    start_w |-> ##2 MOSI_O == $past(DATA_WR_BYTE_I[7], 2);
  endproperty
  a_mosi_msb: assert property (p_mosi_msb)
    else $error("master-out is not the msb of the written byte");
  property p_load;
    start_w |-> ##[1:3] STAT_O.busy;
  endproperty
  a_load: assert property (p_load)
    else $error("written byte did not start a transfer");
  property p_master_out;
    MOSI_OE_O || SCK_OE_O |-> master_w || $past(master_w);
  endproperty
  a_master_out: assert property (p_master_out)
    else $error("master-out or clock driven while not master");
  property p_miso_dir;
    MISO_OE_O |-> !master_w || !$past(master_w);
  endproperty
  a_miso_dir: assert property (p_miso_dir)
    else $error("master-in driven while master");
  property p_miso_off;
    !CFG_O.port_enable_bit && $stable(CFG_O.port_enable_bit) |-> !MISO_OE_O;
  endproperty
  a_miso_off: assert property (p_miso_off)
    else $error("master-in driven while port disabled");
  property p_sel_out;
    CFG_O.select_mode_field[1] && $stable(CFG_O) |-> SEL_OE_O && SEL_O == CFG_O.select_mode_field[0];
  endproperty
  a_sel_out: assert property (p_sel_out)
    else $error("select output does not follow the low mode bit");
  property p_routed;
    $stable(CFG_O) |-> SEL_ROUTED_O == (CFG_O.select_mode_field != 2'h0);
  endproperty
  a_routed: assert property (p_routed)
    else $error("select routing does not match the mode");
  property p_fault;
    master_w && CFG_O.port_enable_bit && CFG_O.select_mode_field == 2'h1 && $fell(SEL_I)
      |-> ##[1:4] (STAT_O.mode_fault_flag && !master_w && !CFG_O.port_enable_bit);
  endproperty
  a_fault: assert property (p_fault)
    else $error("select fall did not cause a mode fault");
  property p_irq;
    IRQ_REQ_O == (STAT_O.transfer_done_flag || STAT_O.mode_fault_flag);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request does not match the flags");
  property p_byte;
    $rose(STAT_O.transfer_done_flag) && master_w |-> ##1 edges_reg == 5'd16;
  endproperty
  a_byte: assert property (p_byte)
    else $error("byte did not take sixteen clock edges");
  property p_reset_mode;
    $rose(RST_B_I) |-> CFG_O.select_mode_field == 2'h1;
  endproperty
  a_reset_mode: assert property (p_reset_mode)
    else $error("select mode after reset is wrong");
endmodule : sms_core_chk
bind sms_core sms_core_chk u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_B_I(RST_B_I), .DATA_WR_I(DATA_WR_I), .DATA_WR_BYTE_I(DATA_WR_BYTE_I),
  .TX_READY_O(TX_READY_O), .CFG_O(CFG_O), .STAT_O(STAT_O), .IRQ_REQ_O(IRQ_REQ_O), .SCK_O(SCK_O),
  .SCK_OE_O(SCK_OE_O), .MOSI_O(MOSI_O), .MOSI_OE_O(MOSI_OE_O), .MISO_OE_O(MISO_OE_O), .SEL_I(SEL_I),
  .SEL_O(SEL_O), .SEL_OE_O(SEL_OE_O), .SEL_ROUTED_O(SEL_ROUTED_O));
`default_nettype wire

// ### testbench/sms_slave_model.sv
// behavioural slave device facing the serial port unit in master mode
`default_nettype none
module sms_slave_model (
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       sel_b_i,
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       load_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            miso_o,
  output logic [7:0]      rx_byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] shift_reg = 8'h00;
  logic       skip_reg  = 1'b0;
  logic       last_reg  = 1'b0;
  always @(posedge load_i) begin
    shift_reg <= tx_byte_i;
    skip_reg  <= cpha_i;
  end
  // phase 1 drives its first bit at load, so the first shift edge is skipped
  always @(sck_i) begin
    if (!sel_b_i && sck_i == !(cpol_i ^ cpha_i)) begin
      rx_byte_o <= {rx_byte_o[6:0], mosi_i};
    end else if (!sel_b_i && skip_reg) begin
      skip_reg <= 1'b0;
    end else if (!sel_b_i) begin
      shift_reg <= {shift_reg[6:0], 1'b0};
    end
  end
  // a released line must not keep showing its last level
  always @(shift_reg or sel_b_i) begin
    if (!sel_b_i) begin
      last_reg = shift_reg[7];
    end
  end
  assign miso_o = sel_b_i ? ~last_reg : shift_reg[7];
endmodule : sms_slave_model
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the serial port unit
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ======
  // stimulus and wires
  logic clk = 1'b0, rst_b = 1'b0, ms_set = 1'b0, ms_clr = 1'b0, pe_set = 1'b0, pe_clr = 1'b0;
  logic cfg_wr = 1'b0, pha = 1'b0, pol = 1'b0, data_wr = 1'b0, data_rd = 1'b0, done_clr = 1'b0;
  logic fault_clr = 1'b0, s_load = 1'b0, tb_sck = 1'b0, tb_mosi = 1'b0, tb_sel = 1'b1, s_sel_b = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [7:0] wr_byte = 8'h00, s_byte = 8'h00, rd_byte, s_rx, got;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, sel_o, sel_oe, routed, tx_rdy, irq, s_miso;
  sms_pkg::sms_cfg_t  cfg;
  sms_pkg::sms_stat_t stat;
  int n_errors = 0, comparisons = 0;
  wire logic sck_w  = sck_oe ? sck_o : tb_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
  wire logic miso_w = miso_oe ? miso_o : s_miso;
  wire logic sel_w  = sel_oe ? sel_o : tb_sel;
  always #10 clk = ~clk;
  sms_core dut (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .MASTER_ENABLE_SET_I(ms_set), .MASTER_ENABLE_CLR_I(ms_clr),
    .PORT_ENABLE_SET_I(pe_set), .PORT_ENABLE_CLR_I(pe_clr), .CFG_WR_I(cfg_wr), .CLOCK_PHASE_I(pha),
    .CLOCK_POLARITY_I(pol), .SELECT_MODE_I(mode), .DATA_WR_I(data_wr), .DATA_WR_BYTE_I(wr_byte),
    .DATA_RD_I(data_rd), .DONE_CLR_I(done_clr), .FAULT_CLR_I(fault_clr), .DATA_RD_BYTE_O(rd_byte),
    .CFG_O(cfg), .STAT_O(stat), .TX_READY_O(tx_rdy), .IRQ_REQ_O(irq), .SCK_I(sck_w), .SCK_O(sck_o),
    .SCK_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE_O(mosi_oe), .MISO_I(miso_w),
    .MISO_O(miso_o), .MISO_OE_O(miso_oe), .SEL_I(sel_w), .SEL_O(sel_o), .SEL_OE_O(sel_oe),
    .SEL_ROUTED_O(routed));
  sms_slave_model u_slave (
    .sck_i(sck_w), .mosi_i(mosi_w), .sel_b_i(s_sel_b), .cpol_i(pol), .cpha_i(pha), .load_i(s_load),
    .tx_byte_i(s_byte), .miso_o(s_miso), .rx_byte_o(s_rx));
  // ======
  // tasks
  task automatic summarize();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic setup(input logic m, input logic ph, input logic po, input logic [1:0] md);
    pe_set = 1'b1;
    ms_set = m;
    ms_clr = !m;
    cfg_wr = 1'b1;
    pha = ph;
    pol = po;
    mode = md;
    tick(1);
    {pe_set, ms_set, ms_clr, cfg_wr} = 4'h0;
    tick(3);
  endtask : setup
  task automatic wr(input logic [7:0] b);
    wr_byte = b;
    data_wr = 1'b1;
    tick(1);
    data_wr = 1'b0;
    tick(2);
  endtask : wr
  // bounded wait for the byte, then read and clear the done flag
  task automatic take(output logic [7:0] b);
    int k;
    k = 0;
    while (stat.transfer_done_flag !== 1'b1 && k < 400) begin
      tick(1);
      k++;
    end
    if (k == 400) begin
      n_errors++;
      summarize();
    end
    data_rd = 1'b1;
    tick(1);
    b = rd_byte;
    data_rd = 1'b0;
    done_clr = 1'b1;
    tick(1);
    done_clr = 1'b0;
    tick(1);
  endtask : take
  task automatic xfer(input logic [7:0] mb, input logic [7:0] sb);
    s_byte = sb;
    s_load = 1'b1;
    tick(1);
    s_load = 1'b0;
    wr(mb);
    take(got);
    chk("master rx", sb, got);
    chk("slave rx", mb, s_rx);
  endtask : xfer
  // external master, polarity 0 phase 0, link clock 160 ns
  task automatic sbyte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      tb_mosi = b[k];
      #80;
      got[k] = miso_w;
      tb_sck = 1'b1;
      #80;
      tb_sck = 1'b0;
    end
    tick(4);
  endtask : sbyte
  // ======
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    #2;
    rst_b = 1'b1;
    tick(1);
    chk("reset mode", 8'h01, {6'h0, cfg.select_mode_field});
    chk("reset pins", 8'h09, {4'h0, routed, sck_oe, miso_oe, tx_rdy});
    for (int i = 0; i < 4; i++) begin
      setup(1'b1, i[1], i[0], 2'h0);
      chk("master pins", 8'h06, {5'h0, mosi_oe, sck_oe, miso_oe | routed});
      xfer(8'hA5 + i[7:0], 8'h3C ^ i[7:0]);
      chk("idle clock", {7'h0, pol}, {7'h0, sck_o});
    end
    for (int m = 2; m < 4; m++) begin
      setup(1'b1, 1'b0, 1'b0, m[1:0]);
      chk("select out", {5'h0, 2'h3, m[0]}, {5'h0, routed, sel_oe, sel_o});
    end
    setup(1'b1, 1'b0, 1'b0, 2'h1);
    tb_sel = 1'b0;
    tick(6);
    chk("fault", 8'h09, {4'h0, stat.mode_fault_flag, cfg.master_enable_bit, cfg.port_enable_bit, irq});
    tb_sel = 1'b1;
    tick(4);
    chk("stays off", 8'h00, {7'h0, cfg.port_enable_bit});
    fault_clr = 1'b1;
    tick(1);
    fault_clr = 1'b0;
    tick(1);
    chk("fault clear", 8'h00, {6'h0, stat.mode_fault_flag, irq});
    s_sel_b = 1'b1;
    setup(1'b0, 1'b0, 1'b0, 2'h1);
    chk("unselected", 8'h00, {7'h0, miso_oe});
    sbyte(8'hFF);
    chk("ignored clock", 8'h00, {7'h0, stat.transfer_done_flag});
    tb_sel = 1'b0;
    tick(4);
    chk("selected", 8'h01, {7'h0, miso_oe});
    sbyte(8'h5A);
    take(got);
    chk("slave rx 4w", 8'h5A, got);
    tb_sel = 1'b1;
    setup(1'b0, 1'b0, 1'b0, 2'h0);
    wr(8'hC3);
    chk("3w slave pins", 8'h02, {6'h0, miso_oe, routed});
    sbyte(8'h69);
    chk("slave tx 3w", 8'hC3, got);
    take(got);
    chk("slave rx 3w", 8'h69, got);
    pe_clr = 1'b1;
    tick(1);
    pe_clr = 1'b0;
    chk("disabled", 8'h00, {7'h0, miso_oe});
    summarize();
  end
endmodule : tb
`default_nettype wire
